/* File: mesb_pkg.sv */
// package for the map error status block: register map, bit positions, carriers
// assumes: 32-bit axi4-lite, word-aligned registers
package mesb_pkg;
  localparam logic [7:0] ADDR_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam int BIT_ME = 14;
  localparam int BIT_MAP_CORR = 13;
  localparam int BIT_MAP_UNCORR = 12;
  localparam int BIT_IPF = 11;
  localparam int BIT_XLAT_CORR = 10;
  localparam int MASK_IVI = 31;
  localparam int MASK_IPF = 11;
  localparam int MASK_CORR = 10;
  localparam int MASK_UNCORR = 9;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // error events from the translation datapath, one-cycle pulses
  typedef struct packed {
    logic mapReadCorr;
    logic mapReadUncorr;
    logic invalidFrame;
    logic invalidFrameLossy;
    logic xlatCorr;
  } mesb_event_s;

  typedef struct packed {
    logic readErrorAddressLock;
    logic busErrorAddressLock;
    logic irqRequest;
    logic impliedVectorRequest;
  } mesb_status_s;
endpackage

/* File: mesb_flag.sv */
// one write-one-to-clear sticky flag; set wins over clear
// assumes: set and clear come from logic on clk
`timescale 1ns/100ps
`default_nettype none
module mesb_flag (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic flag
);
  logic flag_d;
  logic flag_q;

  always_comb begin
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    if (set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule
`default_nettype wire

/* File: mesb_map_errors.sv */
// map error status flags of the adapter error summary register, axi4-lite slave
// assumes: event pulses synchronous to clk; address registers live elsewhere
// status outputs are registered levels; the vector request is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module mesb_map_errors (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // datapath events
  input wire mesb_pkg::mesb_event_s events,
  // status toward address registers and interrupt logic
  output mesb_pkg::mesb_status_s status
);
  // write channel state
  logic awTaken_q;
  logic awTaken_d;
  logic wTaken_q;
  logic wTaken_d;
  logic awReady_q;
  logic awReady_d;
  logic wReady_q;
  logic wReady_d;
  logic [7:0] awAddr_q;
  logic [7:0] awAddr_d;
  logic [31:0] wData_q;
  logic [31:0] wData_d;
  logic [3:0] wStrb_q;
  logic [3:0] wStrb_d;
  logic bValid_q;
  logic bValid_d;
  logic [1:0] bResp_q;
  logic [1:0] bResp_d;
  // read channel state
  logic arReady_q;
  logic arReady_d;
  logic rValid_q;
  logic rValid_d;
  logic [31:0] rData_q;
  logic [31:0] rData_d;
  logic [1:0] rResp_q;
  logic [1:0] rResp_d;
  // software control and status state
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  mesb_pkg::mesb_status_s status_q;
  mesb_pkg::mesb_status_s status_d;

  logic doWrite;
  logic awHit;
  logic wrSummary;
  logic wrMask;
  logic wrMode;
  logic [31:0] readWord;
  logic readHit;
  logic [31:0] wordMask;
  logic [4:0] setVec;
  logic [4:0] clrVec;
  logic [4:0] flagVec;
  logic anyEvent;
  logic anyPending;
  logic xlatOn;

  // bus slave: address and data taken independently, response after both
  always_comb begin
    awTaken_d = awTaken_q;
    wTaken_d = wTaken_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    awReady_d = 1'b0;
    wReady_d = 1'b0;
    doWrite = 1'b0;
    if (s_axi_awvalid && !awTaken_q && !bValid_q) begin
      awTaken_d = 1'b1;
      awReady_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wTaken_q && !bValid_q) begin
      wTaken_d = 1'b1;
      wReady_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (awTaken_q && wTaken_q && !bValid_q) begin
      doWrite = 1'b1;
      awTaken_d = 1'b0;
      wTaken_d = 1'b0;
      bValid_d = 1'b1;
      if (awHit) begin
        bResp_d = mesb_pkg::RESP_OKAY;
      end else begin
        bResp_d = mesb_pkg::RESP_SLVERR;
      end
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wordMask[i*8 +: 8] = {8{wStrb_q[i]}};
    end
  end

  // write address decode
  always_comb begin
    awHit = (awAddr_q == mesb_pkg::ADDR_SUMMARY) || (awAddr_q == mesb_pkg::ADDR_MASK) ||
            (awAddr_q == mesb_pkg::ADDR_MODE);
    wrSummary = doWrite && (awAddr_q == mesb_pkg::ADDR_SUMMARY);
    wrMask = doWrite && (awAddr_q == mesb_pkg::ADDR_MASK);
    wrMode = doWrite && (awAddr_q == mesb_pkg::ADDR_MODE);
  end

  // control registers written by software
  always_comb begin
    mask_d = mask_q;
    mode_d = mode_q;
    if (wrMask) begin
      mask_d = (mask_q & ~wordMask) | (wData_q & wordMask);
    end
    if (wrMode && wStrb_q[0]) begin
      mode_d = wData_q[1:0];
    end
  end

  // flag set and clear terms, order: me, map corr, map uncorr, ipf, xlat corr
  assign xlatOn = (mode_q != 2'h0);
  always_comb begin
    setVec[4] = 1'b0;
    setVec[3] = events.mapReadCorr;
    setVec[2] = events.mapReadUncorr;
    setVec[1] = events.invalidFrame;
    setVec[0] = events.xlatCorr && xlatOn;
    anyEvent = |setVec[3:0];
    anyPending = |flagVec;
    setVec[4] = anyEvent && anyPending;
    clrVec = '0;
    if (wrSummary && wStrb_q[1]) begin
      clrVec = wData_q[mesb_pkg::BIT_XLAT_CORR +: 5];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gFlag
      mesb_flag uFlag (
        .clk(clk),
        .rstn(rstn),
        .set(setVec[g]),
        .clr(clrVec[g]),
        .flag(flagVec[g])
      );
    end
  endgenerate

  // locks and the irq request follow the flags; the vector request follows the events
  always_comb begin
    status_d.readErrorAddressLock = flagVec[3] | flagVec[2];
    status_d.busErrorAddressLock = flagVec[1] | flagVec[0];
    status_d.irqRequest = (flagVec[3] & mask_q[mesb_pkg::MASK_CORR])
                        | (flagVec[2] & mask_q[mesb_pkg::MASK_UNCORR])
                        | (flagVec[1] & mask_q[mesb_pkg::MASK_IPF])
                        | (flagVec[0] & mask_q[mesb_pkg::MASK_CORR]);
    status_d.impliedVectorRequest = events.invalidFrame && events.invalidFrameLossy &&
                                    mask_q[mesb_pkg::MASK_IVI];
  end

  // read data selection
  always_comb begin
    readWord = 32'h0000_0000;
    readHit = 1'b1;
    unique case (s_axi_araddr)
      mesb_pkg::ADDR_SUMMARY: readWord[mesb_pkg::BIT_XLAT_CORR +: 5] = flagVec;
      mesb_pkg::ADDR_MASK: readWord = mask_q;
      mesb_pkg::ADDR_MODE: readWord[1:0] = mode_q;
      default: readHit = 1'b0;
    endcase
  end

  // read channel, one cycle to answer
  always_comb begin
    arReady_d = 1'b0;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (s_axi_arvalid && !arReady_q && !rValid_q) begin
      arReady_d = 1'b1;
      rValid_d = 1'b1;
      rData_d = readWord;
      if (readHit) begin
        rResp_d = mesb_pkg::RESP_OKAY;
      end else begin
        rResp_d = mesb_pkg::RESP_SLVERR;
      end
    end
  end

  // write channel registers; awready and wready are one-cycle pulses
  always_ff @(posedge clk) begin
    if (!rstn) begin
      awTaken_q <= 1'b0;
      wTaken_q <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= 2'h0;
    end else begin
      awTaken_q <= awTaken_d;
      wTaken_q <= wTaken_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
    end
  end

  // read channel registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= 2'h0;
    end else begin
      arReady_q <= arReady_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  // software control registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= mesb_pkg::MASK_RESET;
      mode_q <= mesb_pkg::MODE_RESET;
    end else begin
      mask_q <= mask_d;
      mode_q <= mode_d;
    end
  end

  // status registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign status = status_q;
endmodule
`default_nettype wire

/* File: mesb_map_errors_props.sv */
// checker on the ports of the map error status block
// assumes: bound to mesb_map_errors, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mesb_map_errors_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // events and status
  input wire mesb_pkg::mesb_event_s events,
  input wire mesb_pkg::mesb_status_s status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rHeld;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_RLOCK_C: assert property (events.mapReadCorr |-> ##2 status.readErrorAddressLock)
    else $error("read lock missing");
  AST_RLOCK_U: assert property (events.mapReadUncorr |-> ##2 status.readErrorAddressLock)
    else $error("read lock missing");
  AST_BLOCK_F: assert property (events.invalidFrame |-> ##2 status.busErrorAddressLock)
    else $error("bus lock missing");
  AST_RLOCK_WHY: assert property ($rose(status.readErrorAddressLock) |->
    $past(events.mapReadCorr, 2) || $past(events.mapReadUncorr, 2))
    else $error("read lock no cause");
  AST_BLOCK_WHY: assert property ($rose(status.busErrorAddressLock) |->
    $past(events.invalidFrame, 2) || $past(events.xlatCorr, 2))
    else $error("bus lock no cause");
  AST_IVI_WHY: assert property (status.impliedVectorRequest |->
    $past(events.invalidFrame) && $past(events.invalidFrameLossy))
    else $error("stray vector request");
  AST_R_HOLD: assert property (rHeld |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind mesb_map_errors mesb_map_errors_props u_props (.clk(clk), .rstn(rstn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .events(events), .status(status));
`default_nettype wire

/* File: mesb_map_errors_tb.sv */
// random and directed bench for the map error status flags
// assumes: package and design compiled first
`timescale 1ns/100ps
`default_nettype none
module mesb_map_errors_tb;
  logic clk = 1'b0, rstn = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic [3:0] ws = 4'hf;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr, resp;
  logic [15:0] seed = 16'h2abf;
  mesb_pkg::mesb_event_s ev = 5'h00;
  mesb_pkg::mesb_status_s st;
  int failures = 0, n_tests = 0, cyc = 0, ivi = 0, n0;
  localparam logic [4:0] EV [4] = '{5'h10, 5'h08, 5'h04, 5'h01};
  localparam int FB [4] = '{13, 12, 11, 10};
  localparam int MB [4] = '{10, 9, 11, 10};
  always #10 clk = ~clk;
  mesb_map_errors DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .events(ev), .status(st));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // lock and irq levels after one event, flags clean before
  function automatic logic [31:0] expSt(input int e, input logic [31:0] m);
    return {28'h0, e < 2, e >= 2, m[MB[e]], 1'b0};
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b1;
    @(posedge clk);
    bry <= 1'b0;
    resp = br;
  endtask
  task automatic get(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b1;
    @(posedge clk);
    rry <= 1'b0;
    got = rd;
    resp = rr;
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (st.impliedVectorRequest === 1'b1) ivi++;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h0, got);
    get(mesb_pkg::ADDR_MASK);
    chk("mask", mesb_pkg::MASK_RESET, got);
    pulse(5'h01);
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h0, got);
    chk("status", 32'h0, {28'h0, st});
    put(mesb_pkg::ADDR_MODE, 32'h1);
    chk("bresp", {30'h0, mesb_pkg::RESP_OKAY}, {30'h0, resp});
    get(mesb_pkg::ADDR_MODE);
    chk("mode", 32'h1, got);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      put(mesb_pkg::ADDR_MASK, {seed, seed});
      get(mesb_pkg::ADDR_MASK);
      chk("mask", {seed, seed}, got);
      pulse(EV[i % 4]);
      get(mesb_pkg::ADDR_SUMMARY);
      chk("summary", 32'h1 << FB[i % 4], got);
      chk("status", expSt(i % 4, {seed, seed}), {28'h0, st});
      put(mesb_pkg::ADDR_SUMMARY, 32'h0);
      get(mesb_pkg::ADDR_SUMMARY);
      chk("kept", 32'h1 << FB[i % 4], got);
      put(mesb_pkg::ADDR_SUMMARY, 32'h1 << FB[i % 4]);
      repeat (3) @(posedge clk);
      chk("released", 32'h0, {28'h0, st});
    end
    $display("test flags done");
    put(mesb_pkg::ADDR_MASK, 32'h8000_0000);
    n0 = ivi;
    pulse(5'h06);
    pulse(5'h04);
    chk("vector", n0 + 1, ivi);
    put(mesb_pkg::ADDR_MASK, 32'h0);
    pulse(5'h06);
    chk("vector", n0 + 1, ivi);
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h4800, got);
    put(mesb_pkg::ADDR_SUMMARY, 32'h7c00);
    pulse(5'h10);
    pulse(5'h01);
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h6400, got);
    put(mesb_pkg::ADDR_SUMMARY, 32'h7c00);
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h0, got);
    $display("test vector done");
    put(mesb_pkg::ADDR_MASK, 32'hffff_ffff);
    pulse(5'h10);
    ws <= 4'hd;
    put(mesb_pkg::ADDR_SUMMARY, 32'h7c00);
    ws <= 4'hf;
    get(mesb_pkg::ADDR_SUMMARY);
    chk("strobe", 32'h2000, got);
    chk("status", 32'ha, {28'h0, st});
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    get(mesb_pkg::ADDR_SUMMARY);
    chk("summary", 32'h0, got);
    chk("status", 32'h0, {28'h0, st});
    get(mesb_pkg::ADDR_MASK);
    chk("mask", mesb_pkg::MASK_RESET, got);
    $display("test reset again done");
    put(8'h0c, 32'hffff_ffff);
    chk("bresp", {30'h0, mesb_pkg::RESP_SLVERR}, {30'h0, resp});
    get(8'h10);
    chk("rresp", {30'h0, mesb_pkg::RESP_SLVERR}, {30'h0, resp});
    chk("rdata", 32'h0, got);
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
